// File: rtl/ast_pkg.sv
// constants shared by the serial transmitter
package ast_pkg;
    localparam logic [2:0] AST_OFF_SR = 3'h0;
    localparam logic [2:0] AST_OFF_DR = 3'h1;
    localparam logic [2:0] AST_OFF_CR1 = 3'h2;
    localparam logic [2:0] AST_OFF_CR2 = 3'h3;
    localparam logic [2:0] AST_OFF_BRR = 3'h4;
    localparam logic [2:0] AST_OFF_EXT_TX_PRESCALE_REG = 3'h5;
    localparam logic [2:0] AST_OFF_CCR = 3'h6;
    localparam int AST_SR_TX_BUFFER_EMPTY_FLAG = 7;
    localparam int AST_SR_TC = 6;
    localparam int AST_CR1_T8 = 6;
    localparam int AST_CR1_M = 4;
    localparam int AST_CR2_TIE = 7;
    localparam int AST_CR2_TX_COMPLETE_IRQ_ENABLE = 6;
    localparam int AST_CR2_TE = 3;
    localparam int AST_CR2_SBK = 0;
    localparam int AST_CCR_I = 3;
    localparam logic [7:0] AST_RST_CCR = 8'h08;
    localparam logic [7:0] AST_RST_SR = 8'hC0;
    localparam logic [7:0] AST_RST_ZERO = 8'h00;
    localparam int AST_OSR = 16;
    localparam int AST_CONV_DIV = 2;
    localparam logic [3:0] AST_BITS_8 = 4'hA;
    localparam logic [3:0] AST_BITS_9 = 4'hB;
    typedef enum logic [1:0] {AST_IDLE, AST_DATA, AST_IDLEFR, AST_BRK} ast_state_e;
endpackage : ast_pkg

// File: rtl/ast_baud_gen.sv
// transmit baud tick generator, conventional or extended prescaler
module ast_baud_gen (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic run,
    input wire logic [7:0] baud_select_reg,
    input wire logic [7:0] ext_tx_prescale_reg,
    output logic bit_tick
);
    logic [3:0] pre_r;
    logic [14:0] div_r;
    logic [14:0] top;
    logic [3:0] pf;

    always_comb begin
        case (baud_select_reg[7:6])
            2'h0: pf = 4'h1;
            2'h1: pf = 4'h3;
            2'h2: pf = 4'h4;
            default: pf = 4'hD;
        endcase
        // conventional: 32*PR*TR over 16 ticks gives 2*PR*TR per tick
        if (ext_tx_prescale_reg != 8'h00) begin
            top = 15'(ext_tx_prescale_reg) - 15'h1;
        end else begin
            top = 15'((15'(pf) * 15'(ast_pkg::AST_CONV_DIV)) << baud_select_reg[2:0]) - 15'h1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            div_r <= 15'h0;
            pre_r <= 4'h0;
        end else if (ce) begin
            if (!run) begin
                div_r <= 15'h0;
                pre_r <= 4'h0;
            end else if (div_r >= top) begin
                div_r <= 15'h0;
                pre_r <= pre_r + 4'h1;
            end else begin
                div_r <= div_r + 15'h1;
            end
        end
    end

    assign bit_tick = ce && run && (div_r >= top) && (pre_r == 4'hF);
endmodule : ast_baud_gen

// File: rtl/ast_tx.sv
// asynchronous serial transmitter with registers
// Behaviour
// - frame is start bit, 8 or 9 data bits lsb first, one stop bit
// - word-length bit set sends 9 bits, ninth from CR1 bit T8
// - line low during start bit
// - line high during stop bit
// - disabled transmitter hands pin back to port function when no frame is in progress
// - enabled but idle line rests high
// - idle character is a full frame of ones
// - break is zero frames, then one extra high bit
// - transmit owns a programmable baud generator
// - enabling transmitter takes the pin and sends an idle frame first
// - empty flag clears by status access then data write
// - empty flag sets when buffer moves to shifter
// - empty interrupt when flag, enable set and global mask clear
// - write during transmission goes to buffer, moved at frame end
// - write while idle loads shifter, starts, empty flag set at once
// - complete flag sets after stop or break frame, may interrupt
// - receive input is oversampled to reject noise
// - complete flag clears by same status-then-data sequence
// - break frames repeat while break bit set, then one high bit
// - enable toggle mid-frame queues idle frame and drops buffer
//
// Implementation choices: the plain strobed port and the register offsets.
module ast_tx (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic serial_rx_pin,
    output logic rx_level,
    output logic tx_data,
    output logic tx_pin_owned,
    output logic tx_irq
);
    logic [7:0] sr_r, cr1_r, cr2_r, brr_r, ext_tx_prescale_reg_r, ccr_r;
    logic [8:0] tx_holding_buffer;
    logic buf_full_r;
    logic sr_seen_r;
    logic [9:0] shift_r;
    logic [3:0] cnt_r;
    logic idle_pend_r;
    logic brk_tail_r;
    logic out_r;
    logic te_d_r;
    ast_pkg::ast_state_e st_r;
    logic bit_tick;
    logic busy;
    logic [3:0] nbits;
    logic dr_wr;
    logic frame_end;
    logic load_buf;
    logic load_dir;
    logic te, send_break_bit;
    logic [2:0] rx_s_r;
    logic [2:0] rx_v_r;
    logic rx_lvl_r;

    function automatic logic [9:0] ast_frame(input logic [7:0] d, input logic b8, input logic m);
        // start low in bit 0, stop high after data in 8-bit frames only; 9-bit frames carry b8 in bit 9
        ast_frame = m ? {b8, d, 1'b0} : {1'b1, d, 1'b0};
    endfunction : ast_frame

    assign te = cr2_r[ast_pkg::AST_CR2_TE];
    assign send_break_bit = cr2_r[ast_pkg::AST_CR2_SBK];
    assign busy = (st_r != ast_pkg::AST_IDLE);
    assign nbits = cr1_r[ast_pkg::AST_CR1_M] ? ast_pkg::AST_BITS_9 : ast_pkg::AST_BITS_8;
    assign dr_wr = ce && wr && (addr == ast_pkg::AST_OFF_DR);
    assign frame_end = bit_tick && busy && (cnt_r == nbits - 4'h1);
    assign load_dir = dr_wr && te && !busy && !idle_pend_r && !send_break_bit;
    // a break tail or a break frame must finish before buffered data moves
    assign load_buf = buf_full_r && te && !idle_pend_r && !send_break_bit && !brk_tail_r
        && (!busy || (frame_end && st_r != ast_pkg::AST_BRK));

    ast_baud_gen u_baud (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        // restart the divider with each frame that starts from idle so the start bit lasts a full bit time
        .run(te && (busy || brk_tail_r)),
        .baud_select_reg(brr_r),
        .ext_tx_prescale_reg(ext_tx_prescale_reg_r),
        .bit_tick(bit_tick)
    );

    // registers written by software
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cr1_r <= ast_pkg::AST_RST_ZERO;
            cr2_r <= ast_pkg::AST_RST_ZERO;
            brr_r <= ast_pkg::AST_RST_ZERO;
            ext_tx_prescale_reg_r <= ast_pkg::AST_RST_ZERO;
            ccr_r <= ast_pkg::AST_RST_CCR;
        end else if (ce && wr) begin
            case (addr)
                ast_pkg::AST_OFF_CR1: cr1_r <= wdata;
                ast_pkg::AST_OFF_CR2: cr2_r <= wdata;
                ast_pkg::AST_OFF_BRR: brr_r <= wdata;
                ast_pkg::AST_OFF_EXT_TX_PRESCALE_REG: ext_tx_prescale_reg_r <= wdata;
                ast_pkg::AST_OFF_CCR: ccr_r <= wdata;
                default: ;
            endcase
        end
    end

    // status flags and the clearing sequence
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sr_r <= ast_pkg::AST_RST_SR;
            sr_seen_r <= 1'b0;
        end else if (ce) begin
            if (rd && addr == ast_pkg::AST_OFF_SR) begin
                sr_seen_r <= 1'b1;
            end else if (dr_wr) begin
                sr_seen_r <= 1'b0;
            end
            // set wins over the clear
            if (dr_wr && sr_seen_r) begin
                sr_r[ast_pkg::AST_SR_TX_BUFFER_EMPTY_FLAG] <= 1'b0;
                sr_r[ast_pkg::AST_SR_TC] <= 1'b0;
            end
            if (load_buf || load_dir) begin
                sr_r[ast_pkg::AST_SR_TX_BUFFER_EMPTY_FLAG] <= 1'b1;
            end
            if (frame_end && (st_r == ast_pkg::AST_DATA || st_r == ast_pkg::AST_BRK)) begin
                sr_r[ast_pkg::AST_SR_TC] <= 1'b1;
            end
        end
    end

    // transmit holding buffer
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tx_holding_buffer <= 9'h000;
            buf_full_r <= 1'b0;
        end else if (ce) begin
            if (te && !te_d_r && busy) begin
                buf_full_r <= 1'b0;
            end else if (dr_wr && te && !load_dir) begin
                tx_holding_buffer <= {cr1_r[ast_pkg::AST_CR1_T8], wdata};
                buf_full_r <= 1'b1;
            end else if (load_buf) begin
                buf_full_r <= 1'b0;
            end
        end
    end

    // frame sequencer
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_r <= ast_pkg::AST_IDLE;
            shift_r <= 10'h3FF;
            cnt_r <= 4'h0;
            idle_pend_r <= 1'b0;
            brk_tail_r <= 1'b0;
            out_r <= 1'b1;
            te_d_r <= 1'b0;
        end else if (ce) begin
            te_d_r <= te;
            if (te && !te_d_r) begin
                idle_pend_r <= 1'b1;
            end
            if (!te && !busy) begin
                st_r <= ast_pkg::AST_IDLE;
                out_r <= 1'b1;
            end else begin
                case (st_r)
                    ast_pkg::AST_IDLE: begin
                        cnt_r <= 4'h0;
                        if (!te) begin
                            out_r <= 1'b1;
                        end else if (brk_tail_r) begin
                            // one high bit so the next start edge is seen
                            out_r <= 1'b1;
                            if (bit_tick) begin
                                brk_tail_r <= 1'b0;
                            end
                        end else if (idle_pend_r) begin
                            st_r <= ast_pkg::AST_IDLEFR;
                            idle_pend_r <= 1'b0;
                            out_r <= 1'b1;
                        end else if (send_break_bit) begin
                            st_r <= ast_pkg::AST_BRK;
                            out_r <= 1'b0;
                        end else if (load_dir) begin
                            st_r <= ast_pkg::AST_DATA;
                            shift_r <= ast_frame(wdata, cr1_r[ast_pkg::AST_CR1_T8],
                                cr1_r[ast_pkg::AST_CR1_M]);
                            out_r <= 1'b0;
                        end else if (load_buf) begin
                            st_r <= ast_pkg::AST_DATA;
                            shift_r <= ast_frame(tx_holding_buffer[7:0], tx_holding_buffer[8],
                                cr1_r[ast_pkg::AST_CR1_M]);
                            out_r <= 1'b0;
                        end else begin
                            out_r <= 1'b1;
                        end
                    end
                    ast_pkg::AST_DATA, ast_pkg::AST_IDLEFR, ast_pkg::AST_BRK: begin
                        if (bit_tick) begin
                            cnt_r <= cnt_r + 4'h1;
                            shift_r <= {1'b1, shift_r[9:1]};
                            if (st_r == ast_pkg::AST_DATA) begin
                                // last slot of a 9-bit frame shifts in a 1 as stop
                                out_r <= (cnt_r == nbits - 4'h2) ? 1'b1 : shift_r[1];
                            end
                        end
                        if (frame_end) begin
                            cnt_r <= 4'h0;
                            if (st_r == ast_pkg::AST_BRK && send_break_bit) begin
                                out_r <= 1'b0;
                            end else if (load_buf) begin
                                // back to back frames: next start bit follows the stop bit
                                st_r <= ast_pkg::AST_DATA;
                                shift_r <= ast_frame(tx_holding_buffer[7:0], tx_holding_buffer[8],
                                    cr1_r[ast_pkg::AST_CR1_M]);
                                out_r <= 1'b0;
                            end else begin
                                st_r <= ast_pkg::AST_IDLE;
                                brk_tail_r <= (st_r == ast_pkg::AST_BRK);
                                out_r <= 1'b1;
                            end
                        end
                    end
                    default: st_r <= ast_pkg::AST_IDLE;
                endcase
            end
        end
    end

    // receive pin oversampled by majority of three
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rx_s_r <= 3'h7;
            rx_v_r <= 3'h7;
            rx_lvl_r <= 1'b1;
        end else if (ce) begin
            rx_s_r <= {rx_s_r[1:0], serial_rx_pin};
            rx_v_r <= {rx_v_r[1:0], rx_s_r[1]};
            rx_lvl_r <= (rx_v_r[0] & rx_v_r[1]) | (rx_v_r[1] & rx_v_r[2])
                | (rx_v_r[0] & rx_v_r[2]);
        end
    end

    // read data one cycle after the strobe
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (ce) begin
            if (rd) begin
                case (addr)
                    ast_pkg::AST_OFF_SR: rdata <= sr_r;
                    ast_pkg::AST_OFF_DR: rdata <= 8'h00;
                    ast_pkg::AST_OFF_CR1: rdata <= cr1_r;
                    ast_pkg::AST_OFF_CR2: rdata <= cr2_r;
                    ast_pkg::AST_OFF_BRR: rdata <= brr_r;
                    ast_pkg::AST_OFF_EXT_TX_PRESCALE_REG: rdata <= ext_tx_prescale_reg_r;
                    ast_pkg::AST_OFF_CCR: rdata <= ccr_r;
                    default: rdata <= 8'h00;
                endcase
            end else begin
                rdata <= 8'h00;
            end
        end
    end

    assign tx_data = out_r;
    assign tx_pin_owned = te || busy;
    assign rx_level = rx_lvl_r;
    assign tx_irq = !ccr_r[ast_pkg::AST_CCR_I]
        && ((sr_r[ast_pkg::AST_SR_TX_BUFFER_EMPTY_FLAG] && cr2_r[ast_pkg::AST_CR2_TIE])
        || (sr_r[ast_pkg::AST_SR_TC] && cr2_r[ast_pkg::AST_CR2_TX_COMPLETE_IRQ_ENABLE]));

    start_low_a: assert property (@(posedge ref_clk) disable iff (rst)
        (st_r == ast_pkg::AST_IDLE && $past(st_r) == ast_pkg::AST_IDLE && load_dir && ce)
        |=> !tx_data) else $error("start bit not low");
    stop_high_a: assert property (@(posedge ref_clk) disable iff (rst)
        (frame_end && st_r == ast_pkg::AST_DATA && !load_buf) |=> tx_data)
        else $error("stop bit not high");
    idle_high_a: assert property (@(posedge ref_clk) disable iff (rst)
        (te && !busy && !load_dir && !load_buf && !send_break_bit && ce) |=> tx_data)
        else $error("idle line not high");
    tx_buffer_empty_flag_direct_a: assert property (@(posedge ref_clk) disable iff (rst)
        load_dir |=> sr_r[ast_pkg::AST_SR_TX_BUFFER_EMPTY_FLAG]) else $error("empty flag not set");
    tc_set_a: assert property (@(posedge ref_clk) disable iff (rst)
        (frame_end && st_r != ast_pkg::AST_IDLEFR) |=> sr_r[ast_pkg::AST_SR_TC])
        else $error("complete flag not set");
    clear_seq_a: assert property (@(posedge ref_clk) disable iff (rst)
        (dr_wr && !sr_seen_r && !frame_end) |=> $stable(sr_r[ast_pkg::AST_SR_TC]))
        else $error("complete flag cleared without status access");
    irq_mask_a: assert property (@(posedge ref_clk) disable iff (rst)
        ccr_r[ast_pkg::AST_CCR_I] |-> !tx_irq) else $error("masked irq raised");
    pin_release_a: assert property (@(posedge ref_clk) disable iff (rst)
        (!te && !busy) |-> !tx_pin_owned) else $error("pin held while disabled");
endmodule : ast_tx

// File: verification/ast_serial_peer.sv
// far-side serial receiver model watching the transmit line
module ast_serial_peer #(
    parameter int BIT_CYC = 16
) (
    input wire logic ref_clk,
    input wire logic line,
    input wire logic owned,
    input wire logic nine,
    output logic rx_pin,
    output logic [8:0] word,
    output int frames,
    output logic frame_bad
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [8:0] w;
    int n;
    initial begin
        // our own transmit line stays at mark, as a pulled-up idle line would
        rx_pin = 1'b1;
        word = 9'h000;
        frames = 0;
        frame_bad = 1'b0;
        forever begin
            @(posedge ref_clk);
            if (owned === 1'b1 && line === 1'b0) begin
                n = (nine === 1'b1) ? 9 : 8;
                w = 9'h000;
                repeat (BIT_CYC / 2) @(posedge ref_clk);
                if (line !== 1'b0) frame_bad = 1'b1;
                for (int i = 0; i < n; i++) begin
                    repeat (BIT_CYC) @(posedge ref_clk);
                    w[i] = line;
                end
                repeat (BIT_CYC) @(posedge ref_clk);
                if (line !== 1'b1) frame_bad = 1'b1;
                word = w;
                frames++;
            end
        end
    end
endmodule : ast_serial_peer

// File: verification/async_serial_transmitter_test.sv
// self-checking bench for the serial transmitter
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module async_serial_transmitter_test;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {logic [2:0] a; logic [7:0] v;} ast_row_s;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic nine = 1'b0;
    logic [7:0] rdata;
    logic rx_pin, rx_level, tx_data, tx_pin_owned, tx_irq, frame_bad;
    logic [8:0] word;
    logic [7:0] d;
    int frames, failures = 0, samples_checked = 0, cycles = 0, lows;
    ast_row_s rows[8] = '{'{ast_pkg::AST_OFF_SR, 8'hC0}, '{ast_pkg::AST_OFF_DR, 8'h00},
        '{ast_pkg::AST_OFF_CR1, 8'h00}, '{ast_pkg::AST_OFF_CR2, 8'h00},
        '{ast_pkg::AST_OFF_BRR, 8'h00}, '{ast_pkg::AST_OFF_EXT_TX_PRESCALE_REG, 8'h00},
        '{ast_pkg::AST_OFF_CCR, 8'h08}, '{3'h7, 8'h00}};

    ast_tx DUT (.ref_clk(ref_clk), .rst(rst), .ce(1'b1), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .serial_rx_pin(rx_pin), .rx_level(rx_level), .tx_data(tx_data),
        .tx_pin_owned(tx_pin_owned), .tx_irq(tx_irq));
    ast_serial_peer #(.BIT_CYC(16)) peer (.ref_clk(ref_clk), .line(tx_data),
        .owned(tx_pin_owned), .nine(nine), .rx_pin(rx_pin), .word(word), .frames(frames),
        .frame_bad(frame_bad));

    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    // ceiling well above the roughly 1100 cycles the sequence needs
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            $display("[FAIL] timeout reached");
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test

    // one gap cycle after each strobe keeps every signal to one assignment per step
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
        @(posedge ref_clk);
    endtask : wr_reg

    task automatic rd_reg(input logic [2:0] a, output logic [7:0] v);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 v = rdata;
        @(posedge ref_clk);
    endtask : rd_reg

    task automatic wait_frames(input int n);
        for (int i = 0; i < 1000 && frames < n; i++) @(posedge ref_clk);
    endtask : wait_frames

    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        #1;
        `CHK("tx_data reset", 1'b1, tx_data)
        `CHK("owned reset", 1'b0, tx_pin_owned)
        `CHK("irq reset", 1'b0, tx_irq)
        @(posedge ref_clk);
        foreach (rows[i]) begin
            rd_reg(rows[i].a, d);
            `CHK("reset value", rows[i].v, d)
        end
        $display("register table test done");
        // one bit time of 16 cycles keeps frames short
        wr_reg(ast_pkg::AST_OFF_EXT_TX_PRESCALE_REG, 8'h01);
        wr_reg(ast_pkg::AST_OFF_CR2, 8'h08);
        #1 `CHK("owned on enable", 1'b1, tx_pin_owned)
        lows = 0;
        repeat (150) begin
            @(posedge ref_clk);
            if (tx_data !== 1'b1) lows++;
        end
        `CHK("idle frame high", 0, lows)
        repeat (30) @(posedge ref_clk);
        rd_reg(ast_pkg::AST_OFF_SR, d);
        wr_reg(ast_pkg::AST_OFF_DR, 8'hA5);
        rd_reg(ast_pkg::AST_OFF_SR, d);
        `CHK("sr after direct load", 8'h80, d)
        wr_reg(ast_pkg::AST_OFF_DR, 8'h5A);
        rd_reg(ast_pkg::AST_OFF_SR, d);
        `CHK("sr after buffered write", 8'h00, d)
        wait_frames(1);
        `CHK("first word", 9'h0A5, word)
        wait_frames(2);
        `CHK("second word", 9'h05A, word)
        // peer counts at mid stop bit, the frame ends half a bit later
        repeat (12) @(posedge ref_clk);
        rd_reg(ast_pkg::AST_OFF_SR, d);
        `CHK("sr after frames", 8'hC0, d)
        `CHK("frame shape", 1'b0, frame_bad)
        $display("eight bit test done");
        nine <= 1'b1;
        wr_reg(ast_pkg::AST_OFF_CR1, 8'h50);
        rd_reg(ast_pkg::AST_OFF_SR, d);
        wr_reg(ast_pkg::AST_OFF_DR, 8'h3C);
        wait_frames(3);
        `CHK("nine bit word", 9'h13C, word)
        `CHK("nine bit shape", 1'b0, frame_bad)
        repeat (12) @(posedge ref_clk);
        $display("nine bit test done");
        wr_reg(ast_pkg::AST_OFF_CCR, 8'h00);
        wr_reg(ast_pkg::AST_OFF_CR2, 8'h48);
        `CHK("complete irq", 1'b1, tx_irq)
        wr_reg(ast_pkg::AST_OFF_CCR, 8'h08);
        `CHK("masked irq", 1'b0, tx_irq)
        wr_reg(ast_pkg::AST_OFF_CCR, 8'h00);
        wr_reg(ast_pkg::AST_OFF_CR2, 8'h88);
        `CHK("empty irq", 1'b1, tx_irq)
        wr_reg(ast_pkg::AST_OFF_CR2, 8'h08);
        `CHK("irq disabled", 1'b0, tx_irq)
        $display("interrupt test done");
        wr_reg(ast_pkg::AST_OFF_CR2, 8'h09);
        repeat (40) @(posedge ref_clk);
        `CHK("break low", 1'b0, tx_data)
        repeat (250) @(posedge ref_clk);
        `CHK("break repeats", 1'b0, tx_data)
        wr_reg(ast_pkg::AST_OFF_CR2, 8'h08);
        for (int i = 0; i < 400 && tx_data !== 1'b1; i++) @(posedge ref_clk);
        lows = 0;
        repeat (60) begin
            @(posedge ref_clk);
            if (tx_data !== 1'b1) lows++;
        end
        `CHK("high after break", 0, lows)
        $display("break test done");
        wr_reg(ast_pkg::AST_OFF_CR2, 8'h00);
        `CHK("pin released", 1'b0, tx_pin_owned)
        $display("disable test done");
        end_of_test();
    end
endmodule : async_serial_transmitter_test
